// *** shared/ltc_defines.vh ***
`ifndef LTC_DEFINES_VH
`define LTC_DEFINES_VH
// Overview of operation
// - Logger level trigger: rising or falling, default rising
// - Slope matters only for level sources
// - Logger sources selectable, readable, default immediate
// - Immediate logger source fires once armed
// - Level sources use the named channel
// - Key sources: list run key, on/off keys
// - Immediate transient command overrides source
// - Completion clears waiting-for-step bit
// - Transient delay 0 to 255 ms, default 0
// - Transient sources selectable, readable, default remote
// - External source takes all trigger pins
// - Immediate transient source fires once armed
// - Remote source steps on bus trigger
// - Triggered level stored, copied on step
// - Fixed mode keeps level, step mode moves

// ----------------
// Register offsets (byte addresses)
// ----------------
`define LTC_ADDR_CMD      8'h00
`define LTC_ADDR_TSRC     8'h04
`define LTC_ADDR_LSRC     8'h08
`define LTC_ADDR_DELAY    8'h0c
`define LTC_ADDR_MODE     8'h10
`define LTC_ADDR_TLEVEL   8'h14
`define LTC_ADDR_LEVEL    8'h18
`define LTC_ADDR_STATUS   8'h1c

// ----------------
// Field positions
// ----------------
`define LTC_CMD_INIT_TRAN 0
`define LTC_CMD_INIT_LOG  1
`define LTC_CMD_TRIG_TRAN 2
`define LTC_CMD_TRIG_LOG  3
`define LTC_CMD_BUS_TRG   4
`define LTC_LSRC_SLOPE    4

// ----------------
// Source encodings
// ----------------
`define LTC_TSRC_BUS      3'h0
`define LTC_TSRC_EXT      3'h1
`define LTC_TSRC_IMM      3'h2
`define LTC_TSRC_PIN1     3'h3
`define LTC_TSRC_PIN2     3'h4
`define LTC_TSRC_PIN3     3'h5
`define LTC_LSRC_BUS      4'h0
`define LTC_LSRC_EXT      4'h1
`define LTC_LSRC_IMM      4'h2
`define LTC_LSRC_CURR1    4'h3
`define LTC_LSRC_CURR2    4'h4
`define LTC_LSRC_VOLT1    4'h5
`define LTC_LSRC_VOLT2    4'h6
`define LTC_LSRC_LIST_RUN_KEY_SOURCE     4'h7
`define LTC_LSRC_INPUT_ONOFF_KEY_SOURCE     4'h8

// ----------------
// Reset values and timing
// ----------------
`define LTC_TSRC_RST      3'h0
`define LTC_LSRC_RST      4'h2
`define LTC_SLOPE_RST     1'b0
`define LTC_DELAY_RST     8'h00
`define LTC_TICK_CYCLES   250000

`endif

// *** verilog/ltc_ms_delay.v ***
`include "ltc_defines.vh"

module ltc_ms_delay #(
    parameter MS_CYCLES = `LTC_TICK_CYCLES
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       start_i,
    input  wire [7:0] delay_ms_i,
    output wire       busy_o,
    output wire       done_o
);
    localparam integer TICK_LAST = MS_CYCLES - 1;

    reg  [7:0]  ms_left_reg;
    reg  [17:0] tick_reg;
    reg         busy_reg;
    wire        tick_end;

    assign tick_end = (tick_reg == TICK_LAST[17:0]);
    // Zero delay finishes in the start cycle
    assign done_o = (start_i && (delay_ms_i == 8'h00)) || (busy_reg && (ms_left_reg == 8'h00));
    assign busy_o = busy_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ms_left_reg <= 8'h00;
            tick_reg    <= 18'h00000;
            busy_reg    <= 1'b0;
        end
        else if (start_i && (delay_ms_i != 8'h00))
        begin
            ms_left_reg <= delay_ms_i;
            tick_reg    <= 18'h00000;
            busy_reg    <= 1'b1;
        end
        else if (busy_reg)
        begin
            if (ms_left_reg == 8'h00)
                busy_reg <= 1'b0;
            else if (tick_end)
            begin
                tick_reg    <= 18'h00000;
                ms_left_reg <= ms_left_reg - 8'h01;
            end
            else
                tick_reg <= tick_reg + 18'h00001;
        end
    end
endmodule // ltc_ms_delay

// *** verilog/ltc_axil_slave.v ***
module ltc_axil_slave (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  awaddr_i,
    input  wire        awvalid_i,
    output wire        awready_o,
    input  wire [31:0] wdata_i,
    input  wire [3:0]  wstrb_i,
    input  wire        wvalid_i,
    output wire        wready_o,
    output wire [1:0]  bresp_o,
    output wire        bvalid_o,
    input  wire        bready_i,
    input  wire [7:0]  araddr_i,
    input  wire        arvalid_i,
    output wire        arready_o,
    output wire [31:0] rdata_o,
    output wire [1:0]  rresp_o,
    output wire        rvalid_o,
    input  wire        rready_i,
    output wire        wr_en_o,
    output wire [7:0]  wr_addr_o,
    output wire [31:0] wr_data_o,
    output wire [3:0]  wr_strb_o,
    input  wire        wr_err_i,
    output wire        rd_en_o,
    output wire [7:0]  rd_addr_o,
    input  wire [31:0] rd_data_i,
    input  wire        rd_err_i
);
    reg        aw_have_reg;
    reg [7:0]  awaddr_reg;
    reg        w_have_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;
    reg        bvalid_reg;
    reg [1:0]  bresp_reg;
    reg        rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0]  rresp_reg;

    assign awready_o = !aw_have_reg && !bvalid_reg;
    assign wready_o  = !w_have_reg && !bvalid_reg;
    assign wr_en_o   = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wr_addr_o = awaddr_reg;
    assign wr_data_o = wdata_reg;
    assign wr_strb_o = wstrb_reg;
    assign bvalid_o  = bvalid_reg;
    assign bresp_o   = bresp_reg;
    assign arready_o = !rvalid_reg;
    assign rd_en_o   = arvalid_i && !rvalid_reg;
    assign rd_addr_o = araddr_i;
    assign rvalid_o  = rvalid_reg;
    assign rdata_o   = rdata_reg;
    assign rresp_o   = rresp_reg;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            aw_have_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_have_reg  <= 1'b0;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= 2'h0;
        end
        else
        begin
            if (awvalid_i && awready_o)
            begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= awaddr_i;
            end
            if (wvalid_i && wready_o)
            begin
                w_have_reg <= 1'b1;
                wdata_reg  <= wdata_i;
                wstrb_reg  <= wstrb_i;
            end
            if (wr_en_o)
            begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_err_i ? 2'h2 : 2'h0;
            end
            else if (bvalid_reg && bready_i)
                bvalid_reg <= 1'b0;
            if (rd_en_o)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_data_i;
                rresp_reg  <= rd_err_i ? 2'h2 : 2'h0;
            end
            else if (rvalid_reg && rready_i)
                rvalid_reg <= 1'b0;
        end
    end
endmodule // ltc_axil_slave

// *** verilog/ltc_top.v ***
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`include "ltc_defines.vh"

module ltc_top #(
    parameter MS_CYCLES = `LTC_TICK_CYCLES
) (
    input  wire        CLK_I,
    input  wire        RST_I,
    input  wire [7:0]  AXI_AWADDR_I,
    input  wire        AXI_AWVALID_I,
    output wire        AXI_AWREADY_O,
    input  wire [31:0] AXI_WDATA_I,
    input  wire [3:0]  AXI_WSTRB_I,
    input  wire        AXI_WVALID_I,
    output wire        AXI_WREADY_O,
    output wire [1:0]  AXI_BRESP_O,
    output wire        AXI_BVALID_O,
    input  wire        AXI_BREADY_I,
    input  wire [7:0]  AXI_ARADDR_I,
    input  wire        AXI_ARVALID_I,
    output wire        AXI_ARREADY_O,
    output wire [31:0] AXI_RDATA_O,
    output wire [1:0]  AXI_RRESP_O,
    output wire        AXI_RVALID_O,
    input  wire        AXI_RREADY_I,
    input  wire [2:0]  TRIG_PIN_I,
    input  wire [2:0]  PIN_IS_TRIG_I,
    input  wire [1:0]  CURR_ABOVE_I,
    input  wire [1:0]  VOLT_ABOVE_I,
    input  wire        LIST_RUN_KEY_I,
    input  wire [1:0]  INPUT_ONOFF_KEY_I,
    input  wire        ALL_ONOFF_KEY_I,
    output wire [15:0] ACTIVE_LEVEL_O,
    output wire        STEP_DONE_O,
    output wire        LOG_TRIGGER_O,
    output wire        WAITING_STEP_O
);
    // ----------------
    // States
    // ----------------
    localparam [1:0] T_IDLE  = 2'h0;
    localparam [1:0] T_ARMED = 2'h1;
    localparam [1:0] T_DELAY = 2'h2;

    // ----------------
    // Functions
    // ----------------
    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) && (a <= `LTC_ADDR_STATUS);
        end
    endfunction

    function [15:0] merge;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0]  strb;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 2; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
    endfunction

    // ----------------
    // Declarations
    // ----------------
    wire        wr_en;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        rd_en;
    wire [7:0]  rd_addr;
    reg  [31:0] rd_data;
    wire        wr_err;
    wire        rd_err;

    reg  [2:0]  tsrc_reg;
    reg  [3:0]  lsrc_reg;
    reg         slope_reg;
    reg  [7:0]  delay_reg;
    reg         step_mode_reg;
    reg  [15:0] tlevel_reg;
    reg  [15:0] level_reg;
    reg  [1:0]  tstate_reg;
    reg  [1:0]  tstate_next;
    reg         wtg_reg;
    reg         log_armed_reg;
    reg         step_done_reg;
    reg         log_trig_reg;

    reg  [10:0] sync1_reg;
    reg  [10:0] sync2_reg;
    reg  [10:0] prev_reg;
    wire [10:0] rise;
    wire [10:0] fall;

    wire [15:0] cmd_word;
    wire        cmd_wr;
    wire        init_tran;
    wire        init_log;
    wire        trig_tran_cmd;
    wire        trig_log_cmd;
    wire        bus_trg;

    wire [2:0]  pin_evt;
    wire        ext_evt;
    wire [1:0]  curr_evt;
    wire [1:0]  volt_evt;
    wire        list_run_key_source_evt;
    wire        input_onoff_key_source_evt;
    reg         tsrc_evt;
    reg         lsrc_evt;
    wire        tran_hit;
    wire        log_hit;
    wire        dly_done;
    wire        dly_busy;

    // ----------------
    // Bus slave
    // ----------------
    ltc_axil_slave u_bus (
        .clk_i     (CLK_I),
        .rst_i     (RST_I),
        .awaddr_i  (AXI_AWADDR_I),
        .awvalid_i (AXI_AWVALID_I),
        .awready_o (AXI_AWREADY_O),
        .wdata_i   (AXI_WDATA_I),
        .wstrb_i   (AXI_WSTRB_I),
        .wvalid_i  (AXI_WVALID_I),
        .wready_o  (AXI_WREADY_O),
        .bresp_o   (AXI_BRESP_O),
        .bvalid_o  (AXI_BVALID_O),
        .bready_i  (AXI_BREADY_I),
        .araddr_i  (AXI_ARADDR_I),
        .arvalid_i (AXI_ARVALID_I),
        .arready_o (AXI_ARREADY_O),
        .rdata_o   (AXI_RDATA_O),
        .rresp_o   (AXI_RRESP_O),
        .rvalid_o  (AXI_RVALID_O),
        .rready_i  (AXI_RREADY_I),
        .wr_en_o   (wr_en),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .wr_strb_o (wr_strb),
        .wr_err_i  (wr_err),
        .rd_en_o   (rd_en),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data),
        .rd_err_i  (rd_err)
    );

    assign wr_err = !addr_ok(wr_addr);
    assign rd_err = !addr_ok(rd_addr);

    // ----------------
    // Command strobes
    // ----------------
    assign cmd_wr        = wr_en && (wr_addr == `LTC_ADDR_CMD);
    assign cmd_word      = merge(16'h0000, wr_data[15:0], wr_strb[1:0]);
    assign init_tran     = cmd_wr && cmd_word[`LTC_CMD_INIT_TRAN];
    assign init_log      = cmd_wr && cmd_word[`LTC_CMD_INIT_LOG];
    assign trig_tran_cmd = cmd_wr && cmd_word[`LTC_CMD_TRIG_TRAN];
    assign trig_log_cmd  = cmd_wr && cmd_word[`LTC_CMD_TRIG_LOG];
    assign bus_trg       = cmd_wr && cmd_word[`LTC_CMD_BUS_TRG];

    // ----------------
    // Input synchronisers and edges
    // ----------------
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            sync1_reg <= 11'h000;
            sync2_reg <= 11'h000;
            prev_reg  <= 11'h000;
        end
        else
        begin
            sync1_reg <= {ALL_ONOFF_KEY_I, INPUT_ONOFF_KEY_I, LIST_RUN_KEY_I,
                          VOLT_ABOVE_I, CURR_ABOVE_I, TRIG_PIN_I};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

    // Pins arrive with polarity already applied
    assign pin_evt  = rise[2:0] & PIN_IS_TRIG_I;
    assign ext_evt  = |pin_evt;
    assign curr_evt = slope_reg ? fall[4:3] : rise[4:3];
    assign volt_evt = slope_reg ? fall[6:5] : rise[6:5];
    assign list_run_key_source_evt = rise[7];
    assign input_onoff_key_source_evt = |rise[10:8];

    // ----------------
    // Source selection
    // ----------------
    always @*
    begin
        case (tsrc_reg)
            `LTC_TSRC_BUS:  tsrc_evt = bus_trg;
            `LTC_TSRC_EXT:  tsrc_evt = ext_evt;
            `LTC_TSRC_IMM:  tsrc_evt = 1'b1;
            `LTC_TSRC_PIN1: tsrc_evt = pin_evt[0];
            `LTC_TSRC_PIN2: tsrc_evt = pin_evt[1];
            `LTC_TSRC_PIN3: tsrc_evt = pin_evt[2];
            default:        tsrc_evt = 1'b0;
        endcase
    end

    always @*
    begin
        case (lsrc_reg)
            `LTC_LSRC_BUS:   lsrc_evt = bus_trg;
            `LTC_LSRC_EXT:   lsrc_evt = ext_evt;
            `LTC_LSRC_IMM:   lsrc_evt = 1'b1;
            `LTC_LSRC_CURR1: lsrc_evt = curr_evt[0];
            `LTC_LSRC_CURR2: lsrc_evt = curr_evt[1];
            `LTC_LSRC_VOLT1: lsrc_evt = volt_evt[0];
            `LTC_LSRC_VOLT2: lsrc_evt = volt_evt[1];
            `LTC_LSRC_LIST_RUN_KEY_SOURCE:  lsrc_evt = list_run_key_source_evt;
            `LTC_LSRC_INPUT_ONOFF_KEY_SOURCE:  lsrc_evt = input_onoff_key_source_evt;
            default:         lsrc_evt = 1'b0;
        endcase
    end

    // Software trigger overrides the source
    assign tran_hit = (tstate_reg == T_ARMED) && (tsrc_evt || trig_tran_cmd);
    assign log_hit  = log_armed_reg && (lsrc_evt || trig_log_cmd);

    // ----------------
    // Transient delay
    // ----------------
    ltc_ms_delay #(
        .MS_CYCLES (MS_CYCLES)
    ) u_delay (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .start_i    (tran_hit),
        .delay_ms_i (delay_reg),
        .busy_o     (dly_busy),
        .done_o     (dly_done)
    );

    // ----------------
    // Transient state machine
    // ----------------
    always @*
    begin
        tstate_next = tstate_reg;
        case (tstate_reg)
            T_IDLE:
            begin
                if (init_tran)
                    tstate_next = T_ARMED;
            end
            T_ARMED:
            begin
                if (tran_hit && dly_done)
                    tstate_next = T_IDLE;
                else if (tran_hit)
                    tstate_next = T_DELAY;
            end
            T_DELAY:
            begin
                if (dly_done)
                    tstate_next = T_IDLE;
            end
            default:
                tstate_next = T_IDLE;
        endcase
    end

    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            tstate_reg    <= T_IDLE;
            wtg_reg       <= 1'b0;
            step_done_reg <= 1'b0;
            level_reg     <= 16'h0000;
        end
        else
        begin
            tstate_reg    <= tstate_next;
            step_done_reg <= dly_done;
            if (init_tran && (tstate_reg == T_IDLE))
                wtg_reg <= 1'b1;
            else if (dly_done)
                wtg_reg <= 1'b0;
            if (dly_done)
            begin
                if (step_mode_reg)
                    level_reg <= tlevel_reg;
            end
            else if (wr_en && (wr_addr == `LTC_ADDR_LEVEL))
                level_reg <= merge(level_reg, wr_data[15:0], wr_strb[1:0]);
        end
    end

    // ----------------
    // Logger arming
    // ----------------
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            log_armed_reg <= 1'b0;
            log_trig_reg  <= 1'b0;
        end
        else
        begin
            log_trig_reg <= log_hit;
            if (log_hit)
                log_armed_reg <= 1'b0;
            else if (init_log)
                log_armed_reg <= 1'b1;
        end
    end

    // ----------------
    // Configuration registers
    // ----------------
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            tsrc_reg      <= `LTC_TSRC_RST;
            lsrc_reg      <= `LTC_LSRC_RST;
            slope_reg     <= `LTC_SLOPE_RST;
            delay_reg     <= `LTC_DELAY_RST;
            step_mode_reg <= 1'b0;
            tlevel_reg    <= 16'h0000;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                `LTC_ADDR_TSRC:
                begin
                    if (wr_strb[0] && (wr_data[2:0] <= `LTC_TSRC_PIN3))
                        tsrc_reg <= wr_data[2:0];
                end
                `LTC_ADDR_LSRC:
                begin
                    if (wr_strb[0] && (wr_data[3:0] <= `LTC_LSRC_INPUT_ONOFF_KEY_SOURCE))
                        lsrc_reg <= wr_data[3:0];
                    if (wr_strb[0])
                        slope_reg <= wr_data[`LTC_LSRC_SLOPE];
                end
                `LTC_ADDR_DELAY:
                begin
                    if (wr_strb[0])
                        delay_reg <= wr_data[7:0];
                end
                `LTC_ADDR_MODE:
                begin
                    if (wr_strb[0])
                        step_mode_reg <= wr_data[0];
                end
                `LTC_ADDR_TLEVEL:
                    tlevel_reg <= merge(tlevel_reg, wr_data[15:0], wr_strb[1:0]);
                default:
                begin
                end
            endcase
        end
    end

    // ----------------
    // Read mux
    // ----------------
    always @*
    begin
        case (rd_addr)
            `LTC_ADDR_TSRC:   rd_data = {29'h00000000, tsrc_reg};
            `LTC_ADDR_LSRC:   rd_data = {27'h0000000, slope_reg, lsrc_reg};
            `LTC_ADDR_DELAY:  rd_data = {24'h000000, delay_reg};
            `LTC_ADDR_MODE:   rd_data = {31'h00000000, step_mode_reg};
            `LTC_ADDR_TLEVEL: rd_data = {16'h0000, tlevel_reg};
            `LTC_ADDR_LEVEL:  rd_data = {16'h0000, level_reg};
            `LTC_ADDR_STATUS: rd_data = {28'h0000000, log_armed_reg, dly_busy,
                                         (tstate_reg == T_ARMED), wtg_reg};
            default:          rd_data = 32'h00000000;
        endcase
    end

    // ----------------
    // Outputs
    // ----------------
    assign ACTIVE_LEVEL_O = level_reg;
    assign STEP_DONE_O    = step_done_reg;
    assign LOG_TRIGGER_O  = log_trig_reg;
    assign WAITING_STEP_O = wtg_reg;
endmodule // ltc_top

// *** verif/ltc_far.sv ***
module ltc_far (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [10:0] tog_i,
    output wire [10:0] lines_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] lines_reg;
    // Pins, comparators and keys keep their level until told to flip
    always @(posedge clk_i)
    begin
        if (rst_i)
            lines_reg <= 11'h000;
        else
            lines_reg <= lines_reg ^ tog_i;
    end
    assign lines_o = lines_reg;
endmodule // ltc_far

// *** verif/ltc_chk_asserts.sv ***
module ltc_chk #(
    parameter MS_CYCLES = 10
) (
    input wire        CLK_I,
    input wire        RST_I,
    input wire        AXI_AWVALID_I,
    input wire        AXI_AWREADY_O,
    input wire        AXI_WVALID_I,
    input wire        AXI_WREADY_O,
    input wire [1:0]  AXI_BRESP_O,
    input wire        AXI_BVALID_O,
    input wire        AXI_BREADY_I,
    input wire        AXI_ARVALID_I,
    input wire        AXI_ARREADY_O,
    input wire [31:0] AXI_RDATA_O,
    input wire        AXI_RVALID_O,
    input wire        AXI_RREADY_I,
    input wire [15:0] ACTIVE_LEVEL_O,
    input wire        STEP_DONE_O,
    input wire        LOG_TRIGGER_O,
    input wire        WAITING_STEP_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    done_pulse_a: assert property (STEP_DONE_O |=> !STEP_DONE_O)
        else $error("step done longer than one cycle");
    log_pulse_a: assert property (LOG_TRIGGER_O |=> !LOG_TRIGGER_O)
        else $error("logger trigger longer than one cycle");
    done_armed_a: assert property (STEP_DONE_O |-> $past(WAITING_STEP_O))
        else $error("step done without arming");
    wait_clear_a: assert property (STEP_DONE_O |-> ##[0:1] !WAITING_STEP_O)
        else $error("waiting bit not cleared");
    wr_answer_a: assert property (AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
        |-> ##2 AXI_BVALID_O) else $error("write response late");
    rd_answer_a: assert property (AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O)
        else $error("read response late");
    b_hold_a: assert property (AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O && $stable(AXI_BRESP_O))
        else $error("write response dropped");
    r_hold_a: assert property (AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O && $stable(AXI_RDATA_O))
        else $error("read data dropped");
    rst_idle_a: assert property (disable iff (1'b0) RST_I |=> !WAITING_STEP_O && ACTIVE_LEVEL_O == 16'h0000)
        else $error("not idle after reset");
endmodule // ltc_chk
bind ltc_top ltc_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// *** verif/tb_load_trigger_control.sv ***
`include "ltc_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_load_trigger_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic        clk = 0;
    logic        rst = 1;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd_v;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [2:0]  pin_is_trig = 3'h7;
    logic [10:0] tog = 0, m;
    logic [15:0] lv;
    logic [1:0]  resp_v;
    wire  [10:0] lines;
    wire         awready, wready, bvalid, arready, rvalid, step_done, log_trig, waiting;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] level;
    int          miscompares = 0, num_checks = 0, cyc = 0, nd = 0, nl = 0, t_done = 0, seed = 72545;
    ltc_far FAR (.clk_i(clk), .rst_i(rst), .tog_i(tog), .lines_o(lines));
    ltc_top #(.MS_CYCLES(MS)) DUT (.CLK_I(clk), .RST_I(rst), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
        .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid),
        .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
        .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
        .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .TRIG_PIN_I(lines[2:0]),
        .PIN_IS_TRIG_I(pin_is_trig), .CURR_ABOVE_I(lines[4:3]), .VOLT_ABOVE_I(lines[6:5]),
        .LIST_RUN_KEY_I(lines[7]), .INPUT_ONOFF_KEY_I(lines[9:8]), .ALL_ONOFF_KEY_I(lines[10]),
        .ACTIVE_LEVEL_O(level), .STEP_DONE_O(step_done), .LOG_TRIGGER_O(log_trig), .WAITING_STEP_O(waiting));
    always #2 clk = ~clk;
    // ----
    // Pulse counters and hang limit
    // ----
    always @(negedge clk)
    begin
        cyc++;
        if (step_done === 1'b1)
        begin
            nd++;
            t_done = cyc;
        end
        if (log_trig === 1'b1)
            nl++;
        if (cyc == 30000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ta = 0, tw = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ta && tw))
        begin
            @(negedge clk);
            ta = ta || awready;
            tw = tw || wready;
            @(posedge clk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        resp_v = bresp;
        @(posedge clk);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd_v = rdata;
        resp_v = rresp;
        @(posedge clk);
        rready <= 0;
    endtask
    task automatic ev(input logic [10:0] k);
        @(posedge clk);
        tog <= k;
        @(posedge clk);
        tog <= 0;
    endtask
    task automatic press(input logic [10:0] k);
        ev(k);
        ev(k);
    endtask
    initial
    begin
        int d, s, n0, t0;
        repeat (5) @(posedge clk);
        rst <= 0;
        rd(`LTC_ADDR_TSRC);
        `CHK(rd_v[2:0], 3'h0)
        rd(`LTC_ADDR_LSRC);
        `CHK(rd_v[4:0], 5'h02)
        rd(`LTC_ADDR_DELAY);
        `CHK(rd_v[7:0], 8'h00)
        rd(8'h20);
        `CHK(resp_v, 2'b10)
        wr(8'h20, 0);
        `CHK(resp_v, 2'b10)
        for (int i = 0; i < 9; i++)
        begin
            d = $random(seed) & 16;
            wr(`LTC_ADDR_TSRC, i % 6);
            wr(`LTC_ADDR_LSRC, d | i);
            rd(`LTC_ADDR_TSRC);
            `CHK(rd_v[2:0], 3'(i % 6))
            rd(`LTC_ADDR_LSRC);
            `CHK(rd_v[4:0], 5'(d | i))
        end
        $display("test readback done");
        d = $unsigned($random(seed)) % 4;
        lv = $random(seed);
        wr(`LTC_ADDR_MODE, 1);
        wr(`LTC_ADDR_TLEVEL, lv);
        wr(`LTC_ADDR_DELAY, d);
        wr(`LTC_ADDR_TSRC, 0);
        wr(`LTC_ADDR_CMD, 1);
        rd(`LTC_ADDR_STATUS);
        `CHK(rd_v[1:0], 2'h3)
        n0 = nd;
        press(11'h007);
        repeat (10) @(posedge clk);
        `CHK(nd, n0)
        t0 = cyc;
        wr(`LTC_ADDR_CMD, 32'h10);
        repeat (d * MS + 20) @(posedge clk);
        `CHK(nd, n0 + 1)
        `CHK(level, lv)
        `CHK((t_done - t0) inside {[d * MS:d * MS + 10]}, 1'b1)
        rd(`LTC_ADDR_STATUS);
        `CHK(rd_v[1:0], 2'h0)
        wr(`LTC_ADDR_TLEVEL, ~lv);
        wr(`LTC_ADDR_CMD, 32'h10);
        repeat (d * MS + 20) @(posedge clk);
        `CHK(level, lv)
        $display("test bus step done");
        wr(`LTC_ADDR_MODE, 0);
        wr(`LTC_ADDR_TSRC, 3);
        wr(`LTC_ADDR_DELAY, 0);
        wr(`LTC_ADDR_LEVEL, lv ^ 16'h00ff);
        wr(`LTC_ADDR_CMD, 1);
        n0 = nd;
        wr(`LTC_ADDR_CMD, 4);
        repeat (8) @(posedge clk);
        `CHK(nd, n0 + 1)
        `CHK(level, lv ^ 16'h00ff)
        $display("test fixed mode done");
        wr(`LTC_ADDR_MODE, 1);
        for (s = 1; s < 6; s++)
        begin
            lv = $random(seed);
            wr(`LTC_ADDR_TLEVEL, lv);
            wr(`LTC_ADDR_TSRC, s);
            n0 = nd;
            wr(`LTC_ADDR_CMD, 1);
            if (s > 2)
                press(11'h007 ^ (11'h001 << (s - 3)));
            repeat (8) @(posedge clk);
            `CHK(nd, n0 + (s == 2))
            if (s != 2)
                press(s == 1 ? 11'h002 : 11'h001 << (s - 3));
            repeat (8) @(posedge clk);
            `CHK(nd, n0 + 1)
            `CHK(level, lv)
        end
        $display("test transient sources done");
        for (int i = 0; i < 10; i++)
        begin
            s = (i == 9) ? 8 : i;
            m = (s == 1) ? 11'h001 : (s == 7) ? 11'h080 : (i == 8) ? 11'h100 : 11'h400;
            wr(`LTC_ADDR_LSRC, ((s == 6) << 4) | s);
            n0 = nl;
            wr(`LTC_ADDR_CMD, 2);
            if (s == 3) press(11'h010);
            if (s == 6) ev(11'h040);
            repeat (8) @(posedge clk);
            `CHK(nl, n0 + (s == 2))
            if (s == 0) wr(`LTC_ADDR_CMD, 32'h10);
            else if (s >= 3 && s <= 6) ev(11'h008 << (s - 3));
            else if (s != 2) press(m);
            repeat (8) @(posedge clk);
            `CHK(nl, n0 + 1)
        end
        $display("test logger sources done");
        print_verdict();
    end
endmodule // tb_load_trigger_control
